// File: i2scp_pkg.sv
package i2scp_pkg;

  // ----------------------------------------------------------------
  // bus and sizes
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW     = 8;
  localparam int unsigned DW         = 32;
  localparam int unsigned MAX_PAIRS  = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_AW    = 3;
  localparam int unsigned LVL_W      = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_FMT     = 8'h04;
  localparam logic [7:0] REG_PAIR    = 8'h08;
  localparam logic [7:0] REG_FIFOCFG = 8'h0c;
  localparam logic [7:0] REG_STAT    = 8'h10;
  localparam logic [7:0] REG_TXDATA  = 8'h14;
  localparam logic [7:0] REG_RXDATA  = 8'h18;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W      = 7;
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_MASTER = 1;
  localparam int unsigned CTRL_TX     = 2;
  localparam int unsigned CTRL_TDM    = 3;
  localparam int unsigned CTRL_RJ     = 4;
  localparam int unsigned CTRL_SCKINV = 5;
  localparam int unsigned CTRL_WSINV  = 6;
  localparam logic [6:0]  CTRL_RST    = 7'h00;

  // ----------------------------------------------------------------
  // format register: word length-1, slot length-1, slots-1, divider
  // ----------------------------------------------------------------
  localparam int unsigned FMT_WLEN_LSB = 0;
  localparam int unsigned FMT_SLOT_LSB = 8;
  localparam int unsigned FMT_NSL_LSB  = 16;
  localparam int unsigned FMT_DIV_LSB  = 24;
  localparam logic [31:0] FMT_RST      = 32'h0001_1f1f;
  localparam logic [31:0] FMT_MASK     = 32'hff0f_1f1f;
  localparam logic [4:0]  WLEN_MIN     = 5'h03;

  // ----------------------------------------------------------------
  // pair register: one byte per channel pair
  // ----------------------------------------------------------------
  localparam int unsigned PAIR_STRIDE   = 8;
  localparam int unsigned PAIR_EN       = 0;
  localparam int unsigned PAIR_MONO     = 1;
  localparam int unsigned PAIR_BASE_LSB = 4;
  localparam logic [7:0]  PAIR_MASK     = 8'hf3;
  localparam logic [31:0] PAIR_RST      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // fifo config and status
  // ----------------------------------------------------------------
  localparam int unsigned FC_TXTHR_LSB = 0;
  localparam int unsigned FC_RXTHR_LSB = 8;
  localparam int unsigned FC_DTX       = 16;
  localparam int unsigned FC_DRX       = 17;
  localparam int unsigned FC_FLUSH     = 24;
  localparam logic [31:0] FC_MASK      = 32'h0003_0f0f;
  localparam logic [31:0] FC_RST       = 32'h0000_0000;
  localparam int unsigned ST_URUN      = 8;
  localparam int unsigned ST_ORUN      = 9;
  localparam int unsigned ST_FULL      = 10;
  localparam int unsigned ST_EMPTY     = 11;

endpackage

// File: i2scp_sync.sv
module i2scp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule // i2scp_sync

// File: i2scp_fifo.sv
module i2scp_fifo (
  // clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  // control
  input  wire logic                           flush_in,
  // write side
  input  wire logic                           push_in,
  input  wire logic [i2scp_pkg::DW-1:0]       wdata_in,
  // read side
  input  wire logic                           pop_in,
  output logic      [i2scp_pkg::DW-1:0]       rdata_out,
  // state
  output logic      [i2scp_pkg::LVL_W-1:0]    level_out,
  output logic                                full_out,
  output logic                                empty_out
);
  import i2scp_pkg::*;

  logic [DW-1:0]      mem_r [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [LVL_W-1:0]   lvl_r, lvl_nxt;
  logic               do_push, do_pop;

  assign full_out  = (lvl_r == LVL_W'(FIFO_DEPTH));
  assign empty_out = (lvl_r == '0);
  assign level_out = lvl_r;
  assign rdata_out = mem_r[rp_r];
  // a refused push or pop leaves the pointers alone
  assign do_push   = push_in & ~full_out;
  assign do_pop    = pop_in & ~empty_out;

  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    lvl_nxt = lvl_r;
    if (flush_in) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      lvl_nxt = '0;
    end else begin
      if (do_push) wp_nxt = wp_r + FIFO_AW'(1);
      if (do_pop)  rp_nxt = rp_r + FIFO_AW'(1);
      lvl_nxt = lvl_r + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // storage has no reset; words are only read after a push
  always_ff @(posedge clk_in) begin
    if (do_push && !flush_in) mem_r[wp_r] <= wdata_in;
  end

endmodule // i2scp_fifo

// File: i2scp_port.sv
// Function
// - whole port is master or slave, by one control bit
// - all pairs share clock, select, data
// - one direction and format for all
// - each pair takes any tdm slot
// - word length four to thirty-two bits
// - each pair may run mono
// - all samples pass eight-entry fifo
// - left or right justified data
// - clock and select polarity invertible
// - dma requests from fifo levels
// - zero to four pairs per instance
// - no master clock in port
module i2scp_port #(
  parameter int unsigned NUM_PAIRS = 4
) (
  // system clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  // apb slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [i2scp_pkg::APB_AW-1:0] paddr_in,
  input  wire logic [i2scp_pkg::DW-1:0]    pwdata_in,
  output logic      [i2scp_pkg::DW-1:0]    prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  // dma requests
  output logic                             dma_tx_req_out,
  output logic                             dma_rx_req_out,
  // link clock
  input  wire logic                        link_clk_in,
  // serial pins
  input  wire logic                        sck_in,
  output logic                             sck_out,
  output logic                             sck_oe_out,
  input  wire logic                        ws_in,
  output logic                             ws_out,
  output logic                             ws_oe_out,
  input  wire logic                        sd_in,
  output logic                             sd_out,
  output logic                             sd_oe_out
);
  import i2scp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic slot_hit(input logic [3:0] slot, input logic [31:0] pairs);
    logic       hit;
    logic [3:0] base;
    hit  = 1'b0;
    base = 4'h0;
    for (int p = 0; p < MAX_PAIRS; p++) begin
      base = pairs[p*PAIR_STRIDE+PAIR_BASE_LSB +: 4];
      if (p < NUM_PAIRS && pairs[p*PAIR_STRIDE+PAIR_EN] &&
          (slot == base || (!pairs[p*PAIR_STRIDE+PAIR_MONO] && slot == base + 4'h1))) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // {in word, word bit number} for a bit position in a slot
  function automatic logic [5:0] word_bit(input logic [4:0] pos, input logic [4:0] wlf,
                                          input logic [4:0] slf, input logic rj);
    logic [4:0] off;
    logic [4:0] idx;
    logic       ok;
    off = rj ? (slf - wlf) : 5'h00;
    idx = pos - off;
    ok  = (pos >= off) && (idx <= wlf);
    return {ok, wlf - idx};
  endfunction

  // next {slot, bit} position in the frame
  function automatic logic [8:0] adv_pos(input logic [4:0] pos, input logic [3:0] slot,
                                         input logic [4:0] slf, input logic [3:0] nsf);
    logic [4:0] b;
    logic [3:0] s;
    b = pos + 5'h01;
    s = slot;
    if (pos == slf) begin
      b = 5'h00;
      s = (slot == nsf) ? 4'h0 : slot + 4'h1;
    end
    return {s, b};
  endfunction

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0]       fmt_r, fmt_nxt, pair_r, pair_nxt, fcfg_r, fcfg_nxt;
  logic [DW-1:0]     prdata_r, prdata_nxt, hold_r, hold_nxt;
  logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic              urun_r, urun_nxt, orun_r, orun_nxt;
  logic              dtx_r, dtx_nxt, drx_r, drx_nxt;
  logic              hold_v_r, hold_v_nxt, tx_req_r, tx_req_nxt, tx_seen_r, tx_seen_nxt;
  logic              rx_ack_r, rx_ack_nxt, urun_seen_r, urun_seen_nxt, orun_seen_r, orun_seen_nxt;
  logic [3:0]        c_s;
  logic              f_push, f_pop, f_flush, f_full, f_empty;
  logic [DW-1:0]     f_wdata, f_rdata;
  logic [LVL_W-1:0]  f_level;
  logic              setup, acc, wr_ok, rd_ok, en, txm;
  logic [31:0]       wfmt;

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  logic [2:0]  l_s, p_s;
  logic [7:0]  div_r, div_nxt;
  logic        ph_r, ph_nxt, sck_prev_r, sck_prev_nxt, ws_prev_r, ws_prev_nxt;
  logic        ws_int_r, ws_int_nxt;
  logic [4:0]  cbit_r, cbit_nxt;
  logic [3:0]  cslot_r, cslot_nxt;
  logic [DW-1:0] tx_word_r, tx_word_nxt, rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt;
  logic        l_tx_seen_r, l_tx_seen_nxt, l_tx_ack_r, l_tx_ack_nxt;
  logic        l_rx_req_r, l_rx_req_nxt, l_urun_r, l_urun_nxt, l_orun_r, l_orun_nxt;
  logic        sck_o_r, sck_o_nxt, ws_o_r, ws_o_nxt, sd_o_r, sd_o_nxt;
  logic        sck_oe_r, sck_oe_nxt, ws_oe_r, ws_oe_nxt, sd_oe_r, sd_oe_nxt;
  logic        l_en, master, tick, rise, fall, sck_lvl, ws_lvl, act;
  logic [4:0]  wlf, slf;
  logic [3:0]  nsf;
  logic [5:0]  wb;
  logic [8:0]  npos;
  logic [DW-1:0] word;

  // ----------------------------------------------------------------
  // fifo and crossings
  // ----------------------------------------------------------------
  i2scp_fifo u_fifo (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .flush_in  (f_flush),
    .push_in   (f_push),
    .wdata_in  (f_wdata),
    .pop_in    (f_pop),
    .rdata_out (f_rdata),
    .level_out (f_level),
    .full_out  (f_full),
    .empty_out (f_empty)
  );

  // into link domain: enable, tx word offered, rx word taken
  i2scp_sync #(.W(3)) u_sync_l (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .d_in      ({rx_ack_r, tx_req_r, ctrl_r[CTRL_EN]}),
    .q_out     (l_s)
  );

  // pins into link domain
  i2scp_sync #(.W(3)) u_sync_p (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .d_in      ({sd_in, ws_in, sck_in}),
    .q_out     (p_s)
  );

  // into system domain: tx taken, rx word offered, underrun, overrun
  i2scp_sync #(.W(4)) u_sync_c (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .d_in      ({l_orun_r, l_urun_r, l_rx_req_r, l_tx_ack_r}),
    .q_out     (c_s)
  );

  // ----------------------------------------------------------------
  // apb slave, registers, fifo side of the handshakes
  // ----------------------------------------------------------------
  assign en    = ctrl_r[CTRL_EN];
  assign txm   = ctrl_r[CTRL_TX];
  assign setup = psel_in & ~penable_in;
  assign acc   = psel_in & penable_in & pready_r & ~pslverr_r;
  assign wr_ok = acc & pwrite_in;
  assign rd_ok = acc & ~pwrite_in;

  always_comb begin
    ctrl_nxt = ctrl_r;  fmt_nxt = fmt_r;  pair_nxt = pair_r;  fcfg_nxt = fcfg_r;
    prdata_nxt = '0;  pready_nxt = setup;  pslverr_nxt = 1'b0;
    urun_nxt = urun_r;  orun_nxt = orun_r;
    hold_nxt = hold_r;  hold_v_nxt = hold_v_r;  tx_req_nxt = tx_req_r;  tx_seen_nxt = c_s[0];
    rx_ack_nxt = rx_ack_r;  urun_seen_nxt = c_s[2];  orun_seen_nxt = c_s[3];
    f_push = 1'b0;  f_pop = 1'b0;  f_wdata = pwdata_in;
    f_flush = (wr_ok && paddr_in == REG_FIFOCFG && pwdata_in[FC_FLUSH]) || !en;
    wfmt = pwdata_in & FMT_MASK;
    if (wfmt[FMT_WLEN_LSB +: 5] < WLEN_MIN) wfmt[FMT_WLEN_LSB +: 5] = WLEN_MIN;
    if (setup) begin
      case (paddr_in)
        REG_CTRL:    prdata_nxt = DW'(ctrl_r);
        REG_FMT:     prdata_nxt = fmt_r;
        REG_PAIR:    prdata_nxt = pair_r;
        REG_FIFOCFG: prdata_nxt = fcfg_r;
        REG_STAT: begin
          prdata_nxt = DW'(f_level);
          prdata_nxt[ST_URUN]  = urun_r;
          prdata_nxt[ST_ORUN]  = orun_r;
          prdata_nxt[ST_FULL]  = f_full;
          prdata_nxt[ST_EMPTY] = f_empty;
        end
        REG_TXDATA:  pslverr_nxt = !pwrite_in || !txm || f_full;
        REG_RXDATA: begin
          pslverr_nxt = pwrite_in || txm || f_empty;
          prdata_nxt  = pslverr_nxt ? '0 : f_rdata;
        end
        default:     pslverr_nxt = 1'b1;
      endcase
    end
    if (wr_ok) begin
      case (paddr_in)
        // the control register's master bit is the only master control
        REG_CTRL:    ctrl_nxt = pwdata_in[CTRL_W-1:0];
        REG_FMT:     fmt_nxt  = wfmt;
        REG_PAIR: begin
          for (int p = 0; p < MAX_PAIRS; p++) begin
            pair_nxt[p*PAIR_STRIDE +: PAIR_STRIDE] = (p < NUM_PAIRS) ?
              (pwdata_in[p*PAIR_STRIDE +: PAIR_STRIDE] & PAIR_MASK) : 8'h00;
          end
        end
        REG_FIFOCFG: fcfg_nxt = pwdata_in & FC_MASK;
        REG_STAT: begin
          if (pwdata_in[ST_URUN]) urun_nxt = 1'b0;
          if (pwdata_in[ST_ORUN]) orun_nxt = 1'b0;
        end
        REG_TXDATA:  f_push = 1'b1;
        default:     ;
      endcase
    end
    // tx: fifo head goes to the hold word, offered by toggle
    if (c_s[0] != tx_seen_r) hold_v_nxt = 1'b0;
    if (en && txm && !hold_v_r && !f_empty && !f_flush) begin
      f_pop      = 1'b1;
      hold_nxt   = f_rdata;
      hold_v_nxt = 1'b1;
      tx_req_nxt = ~tx_req_r;
    end
    if (!en) hold_v_nxt = 1'b0;
    // rx: word from link pushed; dropped and flagged when full
    if (!txm && rd_ok && paddr_in == REG_RXDATA) f_pop = 1'b1;
    if (c_s[1] != rx_ack_r) begin
      rx_ack_nxt = c_s[1];
      f_wdata    = rx_data_r;
      f_push     = !f_full;
      if (f_full) orun_nxt = 1'b1;
    end
    // set wins over the clear in the same cycle
    if (c_s[2] != urun_seen_r) urun_nxt = 1'b1;
    if (c_s[3] != orun_seen_r) orun_nxt = 1'b1;
    dtx_nxt = en && txm && fcfg_r[FC_DTX] && (f_level <= fcfg_r[FC_TXTHR_LSB +: LVL_W]);
    drx_nxt = en && !txm && fcfg_r[FC_DRX] && (f_level > fcfg_r[FC_RXTHR_LSB +: LVL_W]);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= CTRL_RST;  fmt_r <= FMT_RST;  pair_r <= PAIR_RST;  fcfg_r <= FC_RST;
      prdata_r <= '0;  pready_r <= 1'b0;  pslverr_r <= 1'b0;
      urun_r <= 1'b0;  orun_r <= 1'b0;  dtx_r <= 1'b0;  drx_r <= 1'b0;
      hold_r <= '0;  hold_v_r <= 1'b0;  tx_req_r <= 1'b0;  tx_seen_r <= 1'b0;
      rx_ack_r <= 1'b0;  urun_seen_r <= 1'b0;  orun_seen_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;  fmt_r <= fmt_nxt;  pair_r <= pair_nxt;  fcfg_r <= fcfg_nxt;
      prdata_r <= prdata_nxt;  pready_r <= pready_nxt;  pslverr_r <= pslverr_nxt;
      urun_r <= urun_nxt;  orun_r <= orun_nxt;  dtx_r <= dtx_nxt;  drx_r <= drx_nxt;
      hold_r <= hold_nxt;  hold_v_r <= hold_v_nxt;  tx_req_r <= tx_req_nxt;  tx_seen_r <= tx_seen_nxt;
      rx_ack_r <= rx_ack_nxt;  urun_seen_r <= urun_seen_nxt;  orun_seen_r <= orun_seen_nxt;
    end
  end

  assign prdata_out     = prdata_r;
  assign pready_out     = pready_r;
  assign pslverr_out    = pslverr_r;
  assign dma_tx_req_out = dtx_r;
  assign dma_rx_req_out = drx_r;

  // ----------------------------------------------------------------
  // link domain: bit clock, frame position, serialiser
  // ----------------------------------------------------------------
  // format fields are quasi-static: change them only while disabled
  assign l_en    = l_s[0];
  assign master  = ctrl_r[CTRL_MASTER];
  assign wlf     = fmt_r[FMT_WLEN_LSB +: 5];
  assign slf     = fmt_r[FMT_SLOT_LSB +: 5];
  assign nsf     = fmt_r[FMT_NSL_LSB +: 4];
  // bit clock is divided from the link clock; no master clock here
  assign tick    = (div_r == 8'h00);
  assign sck_lvl = master ? ph_r : (p_s[0] ^ ctrl_r[CTRL_SCKINV]);
  assign ws_lvl  = master ? ws_int_r : (p_s[1] ^ ctrl_r[CTRL_WSINV]);
  assign rise    = l_en & (master ? (tick & ~ph_r) : (sck_lvl & ~sck_prev_r));
  assign fall    = l_en & (master ? (tick & ph_r) : (~sck_lvl & sck_prev_r));
  assign act     = slot_hit(cslot_r, pair_r);
  assign wb      = word_bit(cbit_r, wlf, slf, ctrl_r[CTRL_RJ]);
  assign npos    = adv_pos(cbit_r, cslot_r, slf, nsf);

  always_comb begin
    div_nxt = div_r;  ph_nxt = ph_r;  sck_prev_nxt = sck_lvl;  ws_prev_nxt = ws_prev_r;
    ws_int_nxt = ws_int_r;  cbit_nxt = cbit_r;  cslot_nxt = cslot_r;
    tx_word_nxt = tx_word_r;  rx_sh_nxt = rx_sh_r;  rx_data_nxt = rx_data_r;
    l_tx_seen_nxt = l_tx_seen_r;  l_tx_ack_nxt = l_tx_ack_r;  l_rx_req_nxt = l_rx_req_r;
    l_urun_nxt = l_urun_r;  l_orun_nxt = l_orun_r;  sd_o_nxt = sd_o_r;
    word = tx_word_r;
    // only master mode can drive the shared clock and select
    sck_oe_nxt = l_en & master;
    ws_oe_nxt  = l_en & master;
    sd_oe_nxt  = l_en & ctrl_r[CTRL_TX];
    if (!l_en) begin
      div_nxt = 8'h00;  ph_nxt = 1'b0;  ws_int_nxt = 1'b0;  ws_prev_nxt = 1'b0;
      cbit_nxt = 5'h00;  cslot_nxt = 4'h0;  sd_o_nxt = 1'b0;  l_tx_seen_nxt = l_s[1]; // drop stale offer
    end else if (master) begin
      div_nxt = tick ? fmt_r[FMT_DIV_LSB +: 8] : div_r - 8'h01;
      if (tick) ph_nxt = ~ph_r;
    end
    // drive edge: select for the next bit, then transmit data
    if (fall) begin
      if (master) begin
        ws_int_nxt = ctrl_r[CTRL_TDM] ? (npos[8:5] == 4'h0) :
                     (npos[8:5] < 4'((5'(nsf) + 5'h01) >> 1));
      end
      if (ctrl_r[CTRL_TX] && act && cbit_r == 5'h00) begin
        if (l_s[1] != l_tx_seen_r) begin
          word          = hold_r; // stable while offered
          l_tx_seen_nxt = l_s[1];
          l_tx_ack_nxt  = ~l_tx_ack_r;
        end else begin
          word       = '0;
          l_urun_nxt = ~l_urun_r; // fifo ran dry: slot sent as zeros
        end
        tx_word_nxt = word;
      end
      sd_o_nxt = ctrl_r[CTRL_TX] && act && wb[5] && word[wb[4:0]];
    end
    // sample edge: receive, then step the frame position
    if (rise) begin
      ws_prev_nxt = ws_lvl;
      if (!ctrl_r[CTRL_TX] && act && wb[5]) begin
        rx_sh_nxt[wb[4:0]] = p_s[2];
        if (wb[4:0] == 5'h00) begin
          if (l_rx_req_r != l_s[2]) begin
            l_orun_nxt = ~l_orun_r; // previous word not yet taken
          end else begin
            rx_data_nxt  = rx_sh_nxt;
            l_rx_req_nxt = ~l_rx_req_r;
          end
          rx_sh_nxt = '0;
        end
      end
      // select edge marks the frame: first bit follows one clock later
      if (ws_lvl && !ws_prev_r) begin
        cbit_nxt  = 5'h00;
        cslot_nxt = 4'h0;
      end else begin
        cbit_nxt  = npos[4:0];
        cslot_nxt = npos[8:5];
      end
    end
    sck_o_nxt = ph_nxt ^ ctrl_r[CTRL_SCKINV];
    ws_o_nxt  = ws_int_nxt ^ ctrl_r[CTRL_WSINV];
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_r <= 8'h00;  ph_r <= 1'b0;  sck_prev_r <= 1'b0;  ws_prev_r <= 1'b0;  ws_int_r <= 1'b0;
      cbit_r <= 5'h00;  cslot_r <= 4'h0;  tx_word_r <= '0;  rx_sh_r <= '0;  rx_data_r <= '0;
      l_tx_seen_r <= 1'b0;  l_tx_ack_r <= 1'b0;  l_rx_req_r <= 1'b0;  l_urun_r <= 1'b0;
      l_orun_r <= 1'b0;  sck_o_r <= 1'b0;  ws_o_r <= 1'b0;  sd_o_r <= 1'b0;
      sck_oe_r <= 1'b0;  ws_oe_r <= 1'b0;  sd_oe_r <= 1'b0;
    end else begin
      div_r <= div_nxt;  ph_r <= ph_nxt;  sck_prev_r <= sck_prev_nxt;  ws_prev_r <= ws_prev_nxt;
      ws_int_r <= ws_int_nxt;  cbit_r <= cbit_nxt;  cslot_r <= cslot_nxt;  tx_word_r <= tx_word_nxt;
      rx_sh_r <= rx_sh_nxt;  rx_data_r <= rx_data_nxt;  l_tx_seen_r <= l_tx_seen_nxt;
      l_tx_ack_r <= l_tx_ack_nxt;  l_rx_req_r <= l_rx_req_nxt;  l_urun_r <= l_urun_nxt;
      l_orun_r <= l_orun_nxt;  sck_o_r <= sck_o_nxt;  ws_o_r <= ws_o_nxt;  sd_o_r <= sd_o_nxt;
      sck_oe_r <= sck_oe_nxt;  ws_oe_r <= ws_oe_nxt;  sd_oe_r <= sd_oe_nxt;
    end
  end

  assign sck_out    = sck_o_r;
  assign sck_oe_out = sck_oe_r;
  assign ws_out     = ws_o_r;
  assign ws_oe_out  = ws_oe_r;
  assign sd_out     = sd_o_r;
  assign sd_oe_out  = sd_oe_r;

endmodule // i2scp_port

// File: i2scp_properties.sv
module i2scp_properties (
  // apb side
  input wire logic                         clk_in,
  input wire logic                         resetn_in,
  input wire logic                         psel_in,
  input wire logic                         penable_in,
  input wire logic [i2scp_pkg::APB_AW-1:0] paddr_in,
  input wire logic [i2scp_pkg::DW-1:0]     prdata_out,
  input wire logic                         pready_out,
  input wire logic                         pslverr_out,
  // link side
  input wire logic                         link_clk_in,
  input wire logic                         sck_out,
  input wire logic                         sck_oe_out,
  input wire logic                         ws_out,
  input wire logic                         ws_oe_out,
  input wire logic                         sd_out
);
  property p_rdy;
    @(posedge clk_in) disable iff (!resetn_in) psel_in && !penable_in |=> pready_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_one;
    @(posedge clk_in) disable iff (!resetn_in) pready_out |=> !pready_out;
  endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_rd0;
    @(posedge clk_in) disable iff (!resetn_in) !pready_out |-> prdata_out == '0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  property p_err;
    @(posedge clk_in) disable iff (!resetn_in) pslverr_out |-> pready_out;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unm;
    @(posedge clk_in) disable iff (!resetn_in) psel_in && !penable_in && paddr_in > 8'h18 |=> pslverr_out;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_oe;
    @(posedge link_clk_in) disable iff (!resetn_in) sck_oe_out == ws_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("clock and select drive apart");
  property p_sd;
    @(posedge link_clk_in) disable iff (!resetn_in)
      sck_oe_out && $past(sck_oe_out) && $changed(sd_out) |-> $fell(sck_out);
  endproperty
  a_sd: assert property (p_sd) else $error("data moved off falling clock");
  property p_ws;
    @(posedge link_clk_in) disable iff (!resetn_in)
      ws_oe_out && $past(ws_oe_out) && $changed(ws_out) |-> $fell(sck_out);
  endproperty
  a_ws: assert property (p_ws) else $error("select moved off falling clock");
endmodule // i2scp_properties

// File: i2scp_codec.sv
module i2scp_codec (
  // serial pins
  input  wire logic       sck_in,
  input  wire logic       ws_in,
  input  wire logic       sd_in,
  // last frame seen
  output logic      [7:0] frame_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ws_r = 1'b0, st_r = 1'b0;
  logic [2:0] n_r = 3'h0;
  logic [7:0] sh_r = 8'h00;
  initial frame_out = 8'h00;
  // listens only; bit after the select rise is slot 0 bit 0
  always @(posedge sck_in) begin
    ws_r <= ws_in;
    sh_r <= {sh_r[6:0], sd_in};
    n_r <= (ws_in && !ws_r) ? 3'h0 : n_r + 3'h1;
    st_r <= st_r | (ws_in && !ws_r);
    if (st_r && n_r == 3'h7) begin
      frame_out <= {sh_r[6:0], sd_in};
    end
  end
endmodule // i2scp_codec

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import i2scp_pkg::*;
  logic        clk_in = 1'b0, link_clk_in = 1'b0, resetn_in = 1'b0;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, er;
  logic [7:0]  paddr_in = 8'h00, frame;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic        pready_out, pslverr_out, dma_tx_req_out, dma_rx_req_out;
  logic        sck_out, sck_oe_out, ws_out, ws_oe_out, sd_out, sd_oe_out;
  // undriven pins read low, as with a pull-down
  wire logic   sck_in = sck_oe_out & sck_out;
  wire logic   ws_in = ws_oe_out & ws_out;
  wire logic   sd_in = sd_oe_out & sd_out;
  int          err_total = 0, samples_checked = 0, cycles = 0;
  logic [39:0] rows [5] = '{40'h00_0000_0000, 40'h04_0001_1f1f, 40'h08_0000_0000,
                            40'h0c_0000_0000, 40'h10_0000_0800};
  always #25 clk_in = ~clk_in;
  initial #7 forever #16 link_clk_in = ~link_clk_in;
  i2scp_port u_i2scp_port (.*);
  i2scp_codec u_i2scp_codec (.sck_in(sck_in), .ws_in(ws_in), .sd_in(sd_in), .frame_out(frame));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i][39:32], 32'h0);
      chk("reset value", rd, rows[i][31:0]);
    end
    $display("test reset done");
    apb(1'b1, REG_FMT, 32'h0);
    apb(1'b0, REG_FMT, 32'h0);
    chk("shortest word", rd, 32'h3);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", er, 1'b1);
    apb(1'b1, REG_FMT, 32'h0301_0303);
    apb(1'b1, REG_FIFOCFG, 32'h0001_0002);
    // no pair on yet: link runs, fifo fills
    apb(1'b1, REG_CTRL, 32'h7);
    repeat (2) @(posedge clk_in);
    chk("dma at low level", dma_tx_req_out, 1'b1);
    for (int i = 0; i < 10; i++)
      apb(1'b1, REG_TXDATA, 32'ha - 32'h5 * i);
    chk("push when full", er, 1'b1);
    apb(1'b0, REG_STAT, 32'h0);
    chk("full status", rd, 32'h408);
    chk("dma above level", dma_tx_req_out, 1'b0);
    chk("no rx dma in tx", dma_rx_req_out, 1'b0);
    $display("test fifo done");
    // disabling flushes; pairs set while disabled
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b1, REG_PAIR, 32'h1);
    apb(1'b1, REG_CTRL, 32'h7);
    // feed during slot 1, ahead of the next slot 0
    @(negedge ws_out);
    repeat (10) @(posedge clk_in);
    apb(1'b1, REG_TXDATA, 32'ha);
    apb(1'b1, REG_TXDATA, 32'h5);
    for (int k = 0; k < 2000 && frame == 8'h00; k++) @(posedge clk_in);
    chk("frame", {24'h0, frame}, 32'ha5);
    chk("master drives", sck_oe_out, 1'b1);
    chk("tx drives data", sd_oe_out, 1'b1);
    $display("test link done");
    results();
  end
endmodule // testbench
bind i2scp_port i2scp_properties u_i2scp_properties (.*);
